// ==== include/system_integration_pkg.sv ====
package system_integration_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int SOURCES = 24;
   // Register addresses on the plain register port.
   localparam logic [15:0] ADDR_BREAK_STATUS = 16'hfe00;
   localparam logic [15:0] ADDR_RESET_CAUSE = 16'hfe01;
   localparam logic [15:0] ADDR_BREAK_FLAG_CTRL = 16'hfe03;
   localparam logic [15:0] ADDR_PENDING_TWO = 16'hfe04;
   localparam logic [15:0] ADDR_PENDING_THREE = 16'hfe05;
   localparam logic [15:0] ADDR_PENDING_FOUR = 16'hfe06;
   localparam logic [15:0] ADDR_CONFIG_ONE = 16'hfe07;
   // Field positions.
   localparam int BIT_EXITED_WAIT = 1;
   localparam int BIT_CLEAR_ENABLE = 0;
   localparam int BIT_SHORT_STOP = 0;
   localparam int BIT_WATCHDOG_DISABLE = 1;
   localparam int CAUSE_POWER_ON = 7;
   localparam int CAUSE_PIN = 6;
   localparam int CAUSE_WATCHDOG = 5;
   localparam int CAUSE_ILL_OPCODE = 4;
   localparam int CAUSE_ILL_ADDRESS = 3;
   localparam int CAUSE_MONITOR = 2;
   localparam int CAUSE_LOW_VOLTAGE = 1;
   // First source of each pending register and the width of the last.
   localparam int MID_BASE = 7;
   localparam int HIGH_BASE = 15;
   localparam int TOP_BASE = 23;
   localparam int TOP_WIDTH = 2;
   // Reset values.
   localparam logic [7:0] RESET_CAUSE_POR = 8'h80;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // Recovery and reset timing in crystal clock cycles.
   localparam int STOP_LONG_CYCLES = 4096;
   localparam int STOP_SHORT_CYCLES = 32;
   localparam int PIN_SAMPLE_CYCLES = 32;
   localparam int RESET_DRIVE_CYCLES = 16;
   localparam int COUNT_W = 13;
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_WAIT = 3'b001,
      ST_STOP_HOLD = 3'b010,
      ST_STOP_RECOVER = 3'b011,
      ST_RESET_DRIVE = 3'b100,
      ST_RESET_SAMPLE = 3'b101
   } seq_state_e;
endpackage : system_integration_pkg

// ==== design/system_integration_control.sv ====
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module system_integration_control
   import system_integration_pkg::*;
#(
   parameter int STOP_LONG = STOP_LONG_CYCLES,
   parameter int STOP_SHORT = STOP_SHORT_CYCLES,
   parameter int PIN_SAMPLE = PIN_SAMPLE_CYCLES,
   parameter int RESET_DRIVE = RESET_DRIVE_CYCLES
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic write_i,
   input wire logic read_i,
   output logic [DATA_W-1:0] rdata_o,
   input wire logic [SOURCES:1] irq_request_i,
   input wire logic interrupt_mask_i,
   input wire logic break_request_i,
   input wire logic break_exit_i,
   input wire logic wait_exec_i,
   input wire logic stop_exec_i,
   input wire logic watchdog_reset_i,
   input wire logic illegal_opcode_reset_i,
   input wire logic illegal_address_reset_i,
   input wire logic monitor_reset_i,
   input wire logic low_voltage_reset_i,
   input wire logic reset_pin_i,
   output logic reset_pin_o,
   output logic reset_pin_oe_o,
   output logic cpu_reset_o,
   output logic vec_force_o,
   output logic mask_clear_o,
   output logic stack_start_o,
   output logic irq_take_o,
   output logic [4:0] irq_source_o,
   output logic cpu_clock_en_o,
   output logic system_clock_out_o,
   output logic crystal_clock_o,
   output logic flag_clear_allow_o,
   output logic in_break_o,
   output logic watchdog_disable_o
);

   // Sequencer state and its next value.
   seq_state_e state;
   seq_state_e next_state;
   // Shared counter for reset drive, pin sampling and stop recovery.
   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] next_count;
   // Registered copy of every source request.
   logic [SOURCES:1] pending;
   // Reset pin synchroniser and its filtered level.
   logic pin_s1;
   logic pin_s2;
   logic pin_s3;
   logic pin_level;
   // Software visible state.
   logic exited_wait;
   logic clear_enable;
   logic short_stop;
   logic [7:0] cause;
   logic in_break;
   // Decoded events of this cycle.
   logic any_internal_reset;
   logic pin_reset;
   logic irq_wake;
   logic [7:0] cause_set;
   logic [COUNT_W-1:0] stop_limit;
   logic first_hit;
   logic [4:0] first_src;

   // Cycle counts as counter-width constants.
   localparam logic [COUNT_W-1:0] LONG_LAST = COUNT_W'(STOP_LONG - 1);
   localparam logic [COUNT_W-1:0] SHORT_LAST = COUNT_W'(STOP_SHORT - 1);
   localparam logic [COUNT_W-1:0] SAMPLE_LAST = COUNT_W'(PIN_SAMPLE - 1);
   localparam logic [COUNT_W-1:0] DRIVE_LAST = COUNT_W'(RESET_DRIVE - 1);
   localparam logic [COUNT_W-1:0] COUNT_ZERO = '0;
   localparam logic [COUNT_W-1:0] COUNT_ONE = COUNT_W'(1);

   // The pin comes from outside, so it passes three flip-flops and a
   // change is only accepted once the last two stages agree.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
         pin_s3 <= 1'b1;
         pin_level <= 1'b1;
      end else begin
         pin_s1 <= reset_pin_i;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         if (pin_s2 == pin_s3) begin
            pin_level <= pin_s3;
         end
      end
   end

   // Pending flags follow the enabled requests with no software help.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         pending <= '0;
      end else begin
         pending <= irq_request_i;
      end
   end

   // All internal reset sources share one level with no ranking.
   assign any_internal_reset = watchdog_reset_i | illegal_opcode_reset_i |
      illegal_address_reset_i | monitor_reset_i | low_voltage_reset_i;
   // An outside pull on the pin counts only while we are not driving it.
   assign pin_reset = !pin_level && (state != ST_RESET_DRIVE) &&
      (state != ST_RESET_SAMPLE);

   // Every cause raised this cycle gets its own bit.
   always_comb begin
      cause_set = ZERO_BYTE;
      cause_set[CAUSE_WATCHDOG] = watchdog_reset_i;
      cause_set[CAUSE_ILL_OPCODE] = illegal_opcode_reset_i;
      cause_set[CAUSE_ILL_ADDRESS] = illegal_address_reset_i;
      cause_set[CAUSE_MONITOR] = monitor_reset_i;
      cause_set[CAUSE_LOW_VOLTAGE] = low_voltage_reset_i;
      cause_set[CAUSE_PIN] = pin_reset;
      if ((state == ST_RESET_SAMPLE) && (count == SAMPLE_LAST) &&
          !pin_level) begin
         cause_set[CAUSE_PIN] = 1'b1;
      end
   end

   // Lowest numbered unmasked source wins; the software interrupt is
   // not a source here, so the mask never blocks it.
   always_comb begin
      first_hit = 1'b0;
      first_src = 5'h00;
      for (int i = SOURCES; i >= 1; i--) begin
         if (pending[i] && !interrupt_mask_i) begin
            first_hit = 1'b1;
            first_src = 5'(i);
         end
      end
   end

   // Any request wakes from low power; the mask is cleared on entry.
   assign irq_wake = |pending;
   // Recovery length chosen by the short recovery bit.
   assign stop_limit = short_stop ? SHORT_LAST : LONG_LAST;

   // Sequencer transitions. Resets win over everything else.
   always_comb begin
      next_state = state;
      next_count = count;
      if (any_internal_reset || pin_reset) begin
         next_state = ST_RESET_DRIVE;
         next_count = COUNT_ZERO;
      end else begin
         unique case (state)
            ST_RUN: begin
               next_count = COUNT_ZERO;
               if (stop_exec_i) begin
                  next_state = ST_STOP_HOLD;
               end else if (wait_exec_i) begin
                  next_state = ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (break_request_i || irq_wake) begin
                  next_state = ST_RUN;
               end
            end
            ST_STOP_HOLD: begin
               next_count = COUNT_ZERO;
               if (irq_wake) begin
                  next_state = ST_STOP_RECOVER;
               end
            end
            ST_STOP_RECOVER: begin
               next_count = count + COUNT_ONE;
               if (count == stop_limit) begin
                  next_state = ST_RUN;
                  next_count = COUNT_ZERO;
               end
            end
            ST_RESET_DRIVE: begin
               next_count = count + COUNT_ONE;
               if (count == DRIVE_LAST) begin
                  next_state = ST_RESET_SAMPLE;
                  next_count = COUNT_ZERO;
               end
            end
            ST_RESET_SAMPLE: begin
               next_count = count + COUNT_ONE;
               if (count == SAMPLE_LAST) begin
                  next_state = ST_RUN;
                  next_count = COUNT_ZERO;
               end
            end
            default: begin
               next_state = ST_RUN;
               next_count = COUNT_ZERO;
            end
         endcase
      end
   end

   // State and counter registers.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         state <= ST_RESET_DRIVE;
         count <= COUNT_ZERO;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // Clock gating and reset outputs follow the next state, so each is a
   // plain flip-flop that lines up with the state register.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         cpu_clock_en_o <= 1'b0;
         system_clock_out_o <= 1'b1;
         crystal_clock_o <= 1'b1;
         cpu_reset_o <= 1'b1;
         reset_pin_o <= 1'b0;
         reset_pin_oe_o <= 1'b1;
      end else begin
         // Wait stops only the CPU; stop halts both generator outputs.
         cpu_clock_en_o <= (next_state == ST_RUN);
         system_clock_out_o <= (next_state != ST_STOP_HOLD) &&
            (next_state != ST_STOP_RECOVER);
         crystal_clock_o <= (next_state != ST_STOP_HOLD);
         cpu_reset_o <= (next_state == ST_RESET_DRIVE) ||
            (next_state == ST_RESET_SAMPLE);
         reset_pin_o <= 1'b0;
         reset_pin_oe_o <= (next_state == ST_RESET_DRIVE);
      end
   end

   // One-cycle pulses toward the CPU.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         mask_clear_o <= 1'b0;
         stack_start_o <= 1'b0;
         vec_force_o <= 1'b0;
      end else begin
         // Entering either low-power mode drops the global mask.
         mask_clear_o <= (state == ST_RUN) &&
            ((next_state == ST_WAIT) || (next_state == ST_STOP_HOLD));
         // Stacking starts the cycle after the wake decision, and after
         // stop only once the recovery count is done.
         stack_start_o <= (next_state == ST_RUN) && irq_wake &&
            ((state == ST_WAIT) || (state == ST_STOP_RECOVER));
         // A new break request forces the software interrupt vector.
         vec_force_o <= break_request_i && !in_break &&
            (next_state != ST_RESET_DRIVE);
      end
   end

   // Arbitration result; held off while any reset is in progress.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         irq_take_o <= 1'b0;
         irq_source_o <= 5'h00;
      end else begin
         irq_take_o <= first_hit && (next_state == ST_RUN);
         irq_source_o <= first_src;
      end
   end

   // Break state lasts from the forced vector until the CPU leaves it.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         in_break <= 1'b0;
      end else if (next_state == ST_RESET_DRIVE) begin
         in_break <= 1'b0;
      end else if (break_request_i) begin
         in_break <= 1'b1;
      end else if (break_exit_i) begin
         in_break <= 1'b0;
      end
   end

   // Peripherals may clear flags outside break, or in break when enabled.
   // Peripherals hold their own half-done two-step sequences while this
   // is low, so the second step after break still clears the flag; a
   // flag cleared while allowed is simply never set again here.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         flag_clear_allow_o <= 1'b1;
         in_break_o <= 1'b0;
      end else begin
         flag_clear_allow_o <= !in_break || clear_enable;
         in_break_o <= in_break;
      end
   end

   // Break-exited-wait flag: set when break ends a wait, cleared by
   // writing zero. The set wins if both land in one cycle.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         exited_wait <= 1'b0;
      end else if ((state == ST_WAIT) && break_request_i &&
                   !any_internal_reset && !pin_reset) begin
         exited_wait <= 1'b1;
      end else if (write_i && (addr_i == ADDR_BREAK_STATUS) &&
                   !wdata_i[BIT_EXITED_WAIT]) begin
         exited_wait <= 1'b0;
      end
   end

   // Break flag control and configuration registers.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         clear_enable <= 1'b0;
         short_stop <= 1'b0;
         watchdog_disable_o <= 1'b0;
      end else if (write_i) begin
         if (addr_i == ADDR_BREAK_FLAG_CTRL) begin
            clear_enable <= wdata_i[BIT_CLEAR_ENABLE];
         end
         if (addr_i == ADDR_CONFIG_ONE) begin
            short_stop <= wdata_i[BIT_SHORT_STOP];
            watchdog_disable_o <= wdata_i[BIT_WATCHDOG_DISABLE];
         end
      end
   end

   // Reset cause register. Power-on leaves only its own bit; a read
   // clears everything, but a cause arriving that cycle still sticks.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         cause <= RESET_CAUSE_POR;
      end else if (read_i && (addr_i == ADDR_RESET_CAUSE)) begin
         cause <= cause_set;
      end else begin
         cause <= cause | cause_set;
      end
   end

   // Read port: data stand in the cycle after the strobe only. The
   // pending registers have no write path at all.
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         rdata_o <= ZERO_BYTE;
      end else if (read_i) begin
         unique case (addr_i)
            ADDR_BREAK_STATUS: begin
               rdata_o <= ZERO_BYTE;
               rdata_o[BIT_EXITED_WAIT] <= exited_wait;
            end
            ADDR_RESET_CAUSE: begin
               rdata_o <= cause;
            end
            ADDR_BREAK_FLAG_CTRL: begin
               rdata_o <= ZERO_BYTE;
               rdata_o[BIT_CLEAR_ENABLE] <= clear_enable;
            end
            ADDR_PENDING_TWO: begin
               rdata_o <= pending[MID_BASE +: DATA_W];
            end
            ADDR_PENDING_THREE: begin
               rdata_o <= pending[HIGH_BASE +: DATA_W];
            end
            ADDR_PENDING_FOUR: begin
               rdata_o <= {6'h00, pending[TOP_BASE +: TOP_WIDTH]};
            end
            ADDR_CONFIG_ONE: begin
               rdata_o <= ZERO_BYTE;
               rdata_o[BIT_SHORT_STOP] <= short_stop;
               rdata_o[BIT_WATCHDOG_DISABLE] <= watchdog_disable_o;
            end
            default: begin
               rdata_o <= ZERO_BYTE;
            end
         endcase
      end else begin
         rdata_o <= ZERO_BYTE;
      end
   end

endmodule : system_integration_control

// ==== tb/system_integration_monitor.sv ====
`timescale 1ns/1ps
// Port-level checker of the block's rules.
module system_integration_monitor
   import system_integration_pkg::*;
(
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic read_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic [SOURCES:1] irq_request_i,
   input wire logic interrupt_mask_i,
   input wire logic break_request_i,
   input wire logic wait_exec_i,
   input wire logic stop_exec_i,
   input wire logic watchdog_reset_i,
   input wire logic reset_pin_oe_o,
   input wire logic cpu_reset_o,
   input wire logic vec_force_o,
   input wire logic mask_clear_o,
   input wire logic irq_take_o,
   input wire logic [4:0] irq_source_o,
   input wire logic cpu_clock_en_o,
   input wire logic system_clock_out_o,
   input wire logic crystal_clock_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   // Lowest numbered request wins, so scan from the top downwards.
   function automatic logic [4:0] lowest_src(input logic [SOURCES:1] r);
      lowest_src = 5'h00;
      for (int i = SOURCES; i >= 1; i--) begin
         if (r[i]) lowest_src = 5'(i);
      end
   endfunction : lowest_src

   // A cause read while no reset is under way.
   sequence s_cause_read;
      read_i && addr_i == ADDR_RESET_CAUSE && !cpu_reset_o;
   endsequence
   // A read of the middle pending register with requests held steady.
   sequence s_mid_read;
      $stable(irq_request_i) && read_i && addr_i == ADDR_PENDING_TWO
         ##1 $stable(irq_request_i);
   endsequence

   AST_RDATA_IDLE: assert property (!read_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   AST_PEND_MID: assert property (s_mid_read |->
      rdata_o == irq_request_i[14:7])
      else $error("middle pending flags differ from requests");
   AST_CAUSE_CLEAR: assert property (s_cause_read ##2 s_cause_read
      |=> rdata_o == 8'h00)
      else $error("cause register not cleared by read");
   AST_MASK_CLEAR: assert property ((wait_exec_i || stop_exec_i)
      && cpu_clock_en_o && !cpu_reset_o |=> mask_clear_o)
      else $error("mask clear missing on low-power entry");
   AST_WAIT_CLOCKS: assert property (wait_exec_i && cpu_clock_en_o
      |=> !cpu_clock_en_o && system_clock_out_o && crystal_clock_o)
      else $error("wait entry clocks wrong");
   AST_STOP_CLOCKS: assert property (stop_exec_i && cpu_clock_en_o
      |=> !system_clock_out_o && !crystal_clock_o)
      else $error("stop entry clocks still running");
   AST_BREAK_SWI: assert property ($rose(break_request_i)
      && cpu_clock_en_o |-> ##[1:3] vec_force_o)
      else $error("break did not force the vector");
   AST_IRQ_PRIO: assert property ((!interrupt_mask_i && cpu_clock_en_o
      && $stable(irq_request_i) && irq_request_i != '0) [*4]
      |-> irq_take_o && irq_source_o == lowest_src(irq_request_i))
      else $error("wrong source chosen");
   AST_MASK_GATE: assert property (interrupt_mask_i [*3]
      |-> !irq_take_o)
      else $error("masked interrupt taken");
   AST_RESET_DRIVE: assert property (watchdog_reset_i
      && !cpu_reset_o |-> ##[1:3] (cpu_reset_o && reset_pin_oe_o))
      else $error("internal reset did not drive the pin");
endmodule : system_integration_monitor

bind system_integration_control system_integration_monitor u_monitor (
   .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
   .read_i(read_i), .rdata_o(rdata_o), .irq_request_i(irq_request_i),
   .interrupt_mask_i(interrupt_mask_i), .break_request_i(break_request_i),
   .wait_exec_i(wait_exec_i), .stop_exec_i(stop_exec_i),
   .watchdog_reset_i(watchdog_reset_i), .reset_pin_oe_o(reset_pin_oe_o),
   .cpu_reset_o(cpu_reset_o), .vec_force_o(vec_force_o),
   .mask_clear_o(mask_clear_o), .irq_take_o(irq_take_o),
   .irq_source_o(irq_source_o), .cpu_clock_en_o(cpu_clock_en_o),
   .system_clock_out_o(system_clock_out_o),
   .crystal_clock_o(crystal_clock_o)
);

// ==== tb/cpu_partner_model.sv ====
`timescale 1ns/1ps
// Reset pin wiring and one peripheral flag with a two-step clear.
module cpu_partner_model (
   input wire logic clock_i,
   input wire logic pin_oe_i,
   input wire logic pin_pull_low_i,
   input wire logic flag_set_i,
   input wire logic step_one_i,
   input wire logic step_two_i,
   input wire logic clear_allow_i,
   output logic pin_level_o,
   output logic flag_o
);
   logic armed; // First clearing step has been seen.
   // The pin has a pull-up, so a released pin reads high.
   assign pin_level_o = !(pin_oe_i || pin_pull_low_i);
   // The second step only clears while the block allows clearing.
   always_ff @(posedge clock_i) begin
      if (flag_set_i) begin
         flag_o <= 1'b1;
      end else if (step_two_i && armed && clear_allow_i) begin
         flag_o <= 1'b0;
      end
      // A blocked second step keeps the first one armed for later.
      if (step_one_i) begin
         armed <= 1'b1;
      end else if (step_two_i && clear_allow_i) begin
         armed <= 1'b0;
      end
   end
endmodule : cpu_partner_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
// Self-checking bench for the system integration block.
module tb_top;
   import system_integration_pkg::*;
   localparam int LONG = 64; // Shortened long recovery keeps runs brief.
   localparam int SHORT = 32;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0] wdata_i = 8'h00;
   logic write_i = 1'b0;
   logic read_i = 1'b0;
   logic [SOURCES:1] irq_request_i = '0;
   logic interrupt_mask_i = 1'b1;
   logic break_request_i = 1'b0;
   logic [4:0] rst_src = 5'h00; // One bit for each internal reset source.
   logic pin_pull = 1'b0; // Outside party pulling the reset pin low.
   // Pulses: flag set, step one, step two, break exit, wait, stop.
   logic [5:0] ctl = 6'h00;
   logic [7:0] rdata_o, seed = 8'h1d;
   logic [4:0] irq_source_o;
   logic reset_pin, reset_pin_oe_o, cpu_reset_o, stack_start_o, irq_take_o;
   logic cpu_clock_en_o, system_clock_out_o, crystal_clock_o, in_break_o;
   logic flag_clear_allow_o, flag;
   int n_errors = 0, n_checks = 0, cycles = 0;

   system_integration_control #(.STOP_LONG(LONG), .STOP_SHORT(SHORT))
   u_system_integration_control (
      .clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
      .rdata_o(rdata_o), .irq_request_i(irq_request_i),
      .interrupt_mask_i(interrupt_mask_i),
      .break_request_i(break_request_i), .break_exit_i(ctl[3]),
      .wait_exec_i(ctl[4]), .stop_exec_i(ctl[5]),
      .watchdog_reset_i(rst_src[0]), .illegal_opcode_reset_i(rst_src[1]),
      .illegal_address_reset_i(rst_src[2]), .monitor_reset_i(rst_src[3]),
      .low_voltage_reset_i(rst_src[4]), .reset_pin_i(reset_pin),
      .reset_pin_o(), .reset_pin_oe_o(reset_pin_oe_o),
      .cpu_reset_o(cpu_reset_o), .vec_force_o(), .mask_clear_o(),
      .stack_start_o(stack_start_o), .irq_take_o(irq_take_o),
      .irq_source_o(irq_source_o), .cpu_clock_en_o(cpu_clock_en_o),
      .system_clock_out_o(system_clock_out_o),
      .crystal_clock_o(crystal_clock_o),
      .flag_clear_allow_o(flag_clear_allow_o), .in_break_o(in_break_o),
      .watchdog_disable_o()
   );
   cpu_partner_model u_cpu_partner_model (
      .clock_i(clock_i), .pin_oe_i(reset_pin_oe_o), .pin_pull_low_i(pin_pull),
      .flag_set_i(ctl[0]), .step_one_i(ctl[1]), .step_two_i(ctl[2]),
      .clear_allow_i(flag_clear_allow_o), .pin_level_o(reset_pin),
      .flag_o(flag)
   );

   // Free-running bus clock at 100 MHz.
   always #5 clock_i = ~clock_i;

   // Cuts a hang short; the run needs far fewer cycles than this.
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         finish_test();
      end
   end

   // Prints the verdict and ends the run.
   task automatic finish_test();
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   // Compares one seen value with its expectation.
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Next random byte from the bench's shift register.
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   // Expected winner: the lowest numbered pending source.
   function automatic logic [4:0] lowest(input logic [SOURCES:1] r);
      lowest = 5'h00;
      for (int i = SOURCES; i >= 1; i--) begin
         if (r[i]) lowest = 5'(i);
      end
   endfunction : lowest

   // One-cycle register write.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      write_i <= 1'b1;
      @(posedge clock_i);
      write_i <= 1'b0;
   endtask : wr

   // One-cycle read; data is taken in the following cycle only.
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clock_i);
      addr_i <= a;
      read_i <= 1'b1;
      @(posedge clock_i);
      read_i <= 1'b0;
      #1 d = rdata_o;
   endtask : rd

   // Read and compare in one go.
   task automatic rc(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      check(d, exp);
   endtask : rc

   // One-cycle pulse on a control bit, settled on return.
   task automatic pulse(input int i);
      @(posedge clock_i);
      ctl <= 6'(1 << i);
      @(posedge clock_i);
      ctl <= 6'h00;
      #1;
   endtask : pulse

   // Counts edges until a signal reaches a level, giving up at a limit.
   task automatic await(ref logic s, input logic lvl, input int lim,
                        output int n);
      n = 0;
      #1;
      while (s !== lvl && n < lim) begin
         @(posedge clock_i);
         #1;
         n++;
      end
   endtask : await

   initial begin
      logic [SOURCES:1] r;
      logic [7:0] d;
      int n, lim;
      repeat (3) @(posedge clock_i);
      resetn_i <= 1'b1;
      await(cpu_reset_o, 1'b0, 200, n);
      rc(ADDR_RESET_CAUSE, RESET_CAUSE_POR);
      rc(ADDR_RESET_CAUSE, ZERO_BYTE);
      wr(ADDR_BREAK_FLAG_CTRL, 8'h01);
      rc(ADDR_BREAK_FLAG_CTRL, 8'h01);
      rc(16'hfe02, ZERO_BYTE);
      // Random request patterns, with all-clear and all-set corners.
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         r[8:1] = seed;
         seed = lfsr(seed);
         r[16:9] = seed;
         seed = lfsr(seed);
         r[24:17] = seed;
         if (k == 0) r = '0;
         if (k == 1) r = '1;
         @(posedge clock_i);
         irq_request_i <= r;
         interrupt_mask_i <= k[1];
         rc(ADDR_PENDING_TWO, r[14:7]);
         wr(ADDR_PENDING_THREE, ~r[22:15]);
         rc(ADDR_PENDING_THREE, r[22:15]);
         rc(ADDR_PENDING_FOUR, {6'h00, r[24:23]});
         check(irq_take_o, !k[1] && r != '0);
         check(irq_source_o, k[1] ? 5'h00 : lowest(r));
      end
      @(posedge clock_i);
      irq_request_i <= '0;
      interrupt_mask_i <= 1'b1;
      // Wait, then wake on an enabled request.
      pulse(4);
      check(cpu_clock_en_o, 1'b0);
      check(system_clock_out_o, 1'b1);
      repeat (3) @(posedge clock_i);
      irq_request_i[9] <= 1'b1;
      await(stack_start_o, 1'b1, 8, n);
      check(n <= 4 && cpu_clock_en_o, 1'b1);
      @(posedge clock_i);
      irq_request_i <= '0;
      // Break ends wait; clearing enabled, so the clear sticks.
      pulse(4);
      pulse(0);
      @(posedge clock_i);
      break_request_i <= 1'b1;
      await(in_break_o, 1'b1, 8, n);
      rd(ADDR_BREAK_STATUS, d);
      check(d[BIT_EXITED_WAIT], 1'b1);
      pulse(1);
      pulse(2);
      @(posedge clock_i) break_request_i <= 1'b0;
      pulse(3);
      check(flag, 1'b0);
      wr(ADDR_BREAK_STATUS, ZERO_BYTE);
      rc(ADDR_BREAK_STATUS, 8'h00);
      // First step before break, second blocked inside it.
      pulse(0);
      pulse(1);
      wr(ADDR_BREAK_FLAG_CTRL, ZERO_BYTE);
      @(posedge clock_i);
      break_request_i <= 1'b1;
      await(in_break_o, 1'b1, 8, n);
      check(flag_clear_allow_o, 1'b0);
      pulse(2);
      check(flag, 1'b1);
      @(posedge clock_i) break_request_i <= 1'b0;
      pulse(3);
      pulse(2);
      check(flag, 1'b0);
      // Stop with short and then long recovery.
      for (int s = 0; s < 2; s++) begin
         wr(ADDR_CONFIG_ONE, {6'h00, s[0], !s[0]});
         rc(ADDR_CONFIG_ONE, {6'h00, s[0], !s[0]});
         pulse(5);
         check({system_clock_out_o, crystal_clock_o}, 2'b00);
         repeat (5) @(posedge clock_i);
         irq_request_i[20] <= 1'b1;
         await(stack_start_o, 1'b1, 500, n);
         lim = s == 0 ? SHORT : LONG;
         check(n >= lim && n <= lim + 4, 1'b1);
         @(posedge clock_i);
         irq_request_i <= '0;
      end
      // Every internal reset source, then the outside pin.
      for (int i = 0; i < 6; i++) begin
         @(posedge clock_i);
         if (i < 5) rst_src <= 5'(1 << i);
         else pin_pull <= 1'b1;
         repeat (6) @(posedge clock_i);
         rst_src <= 5'h00;
         pin_pull <= 1'b0;
         #1;
         check({cpu_reset_o, reset_pin_oe_o}, 2'b11);
         await(cpu_reset_o, 1'b0, 200, n);
         rc(ADDR_RESET_CAUSE, i < 5 ? 8'h20 >> i : 8'h40);
      end
      finish_test();
   end
endmodule : tb_top
